// [sifa_pkg.sv]
// Constants shared by the control logic of the clock buffer.
package sifa_pkg;

    // ************************************************************
    // Register offsets and reset values.
    // ************************************************************
    localparam logic [7:0] REG_READBACK_LENGTH     = 8'h07;
    localparam logic [7:0] REG_FEATURE_UNLOCK      = 8'h08;
    localparam logic [7:0] REG_FEATURE_BIT_POINTER = 8'h09;
    localparam logic [7:0] REG_FEATURE_BIT_COMMAND = 8'h0a;
    localparam logic [4:0] READBACK_LEN_RESET      = 5'h08;
    localparam logic [7:0] UNLOCK_CODE             = 8'hbb;
    localparam logic [7:0] FEATURE_PTR_RESET       = 8'h00;

    // ************************************************************
    // Field positions.
    // ************************************************************
    localparam int CMD_WRITE_ENABLE_BIT = 7;
    localparam int CMD_READ_STATE_BIT   = 6;
    localparam int CMD_WRITE_STATE_BIT  = 1;
    localparam int FEATURE_BITS         = 256;
    localparam int DIFF_OUTPUTS         = 19;

    // ************************************************************
    // Bus address and timing.
    // ************************************************************
    localparam logic [6:0] SMBUS_DEVICE_ADDR = 7'h6c;
    localparam int CLK_FREQ_MHZ       = 10;
    localparam int PWRUP_DELAY_US     = 300;
    localparam int PWRUP_DELAY_CYCLES = PWRUP_DELAY_US * CLK_FREQ_MHZ;
    localparam int PWRUP_MAX_US       = 1800;

    // ************************************************************
    // State encodings.
    // ************************************************************
    typedef enum logic [3:0] {
        SLV_IDLE      = 4'b0000,
        SLV_ADDR      = 4'b0001,
        SLV_ADDR_ACK  = 4'b0010,
        SLV_CMD       = 4'b0011,
        SLV_CMD_ACK   = 4'b0100,
        SLV_WDATA     = 4'b0101,
        SLV_WDATA_ACK = 4'b0110,
        SLV_RDATA     = 4'b0111,
        SLV_RDATA_ACK = 4'b1000,
        SLV_RDATA_NXT = 4'b1001
    } sifa_slv_state_t;

    typedef enum logic [1:0] {
        SEQ_OFF   = 2'b00,
        SEQ_DELAY = 2'b01,
        SEQ_WAIT  = 2'b10,
        SEQ_RUN   = 2'b11
    } sifa_seq_state_t;

endpackage

// [sifa_powerup_seq.sv]
// Power-up sequencer that gates the differential clock outputs.
`timescale 1ns/10ps
module sifa_powerup_seq #(
    parameter int PWRUP_MAX_CYCLES = sifa_pkg::PWRUP_MAX_US
                                     * sifa_pkg::CLK_FREQ_MHZ
) (
    input  wire logic                              clk,
    input  wire logic                              rst,
    input  wire logic                              supplyOk,
    input  wire logic                              refClkValid,
    input  wire logic                              powerDownN,
    input  wire logic                              pllLocked,
    output logic [sifa_pkg::DIFF_OUTPUTS-1:0]      differentialClockOutputs
);
    import sifa_pkg::*;

    sifa_seq_state_t state_q;
    sifa_seq_state_t state_d;
    logic [11:0]     delayCnt_q;
    logic [15:0]     latency_q;
    wire             delayDone = delayCnt_q == 12'(PWRUP_DELAY_CYCLES - 1);
    wire             inputsGood = refClkValid && powerDownN;

    // ************************************************************
    // State transitions.
    // ************************************************************
    always_comb begin
        state_d = state_q;
        case (state_q)
            SEQ_OFF:   if (supplyOk) state_d = SEQ_DELAY;
            SEQ_DELAY: if (!supplyOk) state_d = SEQ_OFF;
                       else if (delayDone) state_d = SEQ_WAIT;
            SEQ_WAIT:  if (!supplyOk) state_d = SEQ_OFF;
                       else if (inputsGood && pllLocked) begin
                           state_d = SEQ_RUN;
                       end
            SEQ_RUN:   if (!supplyOk) state_d = SEQ_OFF;
                       else if (!inputsGood || !pllLocked) begin
                           state_d = SEQ_WAIT;
                       end
            default:   state_d = SEQ_OFF;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q                  <= SEQ_OFF;
            delayCnt_q               <= 12'h000;
            latency_q                <= 16'h0000;
            differentialClockOutputs <= '0;
        end else begin
            state_q    <= state_d;
            delayCnt_q <= (state_q == SEQ_DELAY) ? delayCnt_q + 12'h001
                                                 : 12'h000;
            latency_q  <= (state_q == SEQ_OFF || state_q == SEQ_RUN)
                          ? 16'h0000 : latency_q + 16'h0001;
            differentialClockOutputs <= (state_d == SEQ_RUN)
                                        ? '1 : '0;
        end
    end

    // ************************************************************
    // Assertions.
    // ************************************************************
    property p_delay_len;
        @(posedge clk) disable iff (rst)
        (state_q == SEQ_DELAY && state_d == SEQ_WAIT)
            |-> delayCnt_q == 12'(PWRUP_DELAY_CYCLES - 1);
    endproperty
    a_delay_len: assert property (p_delay_len)
        else $error("Power-up delay length wrong.");

    property p_wait_inputs;
        @(posedge clk) disable iff (rst)
        (state_q == SEQ_WAIT && supplyOk && inputsGood && pllLocked)
            |=> state_q == SEQ_RUN && differentialClockOutputs == '1;
    endproperty
    a_wait_inputs: assert property (p_wait_inputs)
        else $error("Sequencer did not enter run state.");

    property p_outputs_gated;
        @(posedge clk) disable iff (rst)
        (differentialClockOutputs != '0) |-> state_q == SEQ_RUN;
    endproperty
    a_outputs_gated: assert property (p_outputs_gated)
        else $error("Outputs enabled outside run state.");

    property p_no_clock_off;
        @(posedge clk) disable iff (rst)
        (!refClkValid || !pllLocked) |=> differentialClockOutputs == '0;
    endproperty
    a_no_clock_off: assert property (p_no_clock_off)
        else $error("Outputs enabled without clock or lock.");

    property p_total_latency;
        @(posedge clk) disable iff (rst)
        (state_q == SEQ_RUN && $past(state_q) == SEQ_WAIT)
            |-> latency_q < 16'(PWRUP_MAX_CYCLES);
    endproperty
    a_total_latency: assert property (p_total_latency)
        else $error("Power-up latency exceeded.");

    c_run: cover property (@(posedge clk) disable iff (rst)
        state_q == SEQ_WAIT ##1 state_q == SEQ_RUN);
    c_lose_lock: cover property (@(posedge clk) disable iff (rst)
        state_q == SEQ_RUN ##1 state_q == SEQ_WAIT);

endmodule

// [sifa_smbus_feature_access.sv]
// SMBus slave, byte count and locked feature-bit access of a clock buffer.
// Operation
// - Byte 7 low five bits set read-back length, reset to 01000.
// - Byte 8 is write-only and gates access to bytes 9 and 10.
// - Writing 0xbb to byte 8 opens bytes 9 and 10.
// - Without unlock, writes to 9 and 10 are ignored, reads give zero.
// - Byte 9 holds the 8-bit address selecting one feature bit.
// - Reading byte 10 shows the selected feature bit in bit 6.
// - Byte 10 write updates the addressed bit from bit 1 if bit 7 set.
// - After supply detect, wait the power-up delay in state one.
// - State two waits for valid reference clock and power-down released.
// - On PLL lock, enter state three and enable all outputs.
// - Whole power-up completes within 1.8 ms given a valid clock.
// - Without input clock or lock, all nineteen outputs stay disabled.
// - In power-down, settings are kept and the bus is ignored.
`timescale 1ns/10ps
module sifa_smbus_feature_access #(
    parameter logic [255:0] FEATURE_DEFAULT  = '0,
    parameter int           PWRUP_MAX_CYCLES = sifa_pkg::PWRUP_MAX_US
                                               * sifa_pkg::CLK_FREQ_MHZ
) (
    input  wire logic                              clk,
    input  wire logic                              rst,
    input  wire logic                              scl,
    input  wire logic                              sdaIn,
    output logic                                   sdaOut,
    output logic                                   sdaOeN,
    input  wire logic                              power_down_n,
    input  wire logic                              supplyOk,
    input  wire logic                              refClkValid,
    input  wire logic                              pllLocked,
    output logic [sifa_pkg::DIFF_OUTPUTS-1:0]      differentialClockOutputs
);
    import sifa_pkg::*;

    // ************************************************************
    // Input synchronisers.
    // ************************************************************
    wire  [5:0] pinRaw = {pllLocked, refClkValid, supplyOk,
                          power_down_n, sdaIn, scl};
    logic [5:0] meta_q;
    logic [5:0] sync_q;
    logic       sclPrev_q;
    logic       sdaPrev_q;

    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : gen_sync
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    // Bus pins and power-down idle high, status pins low.
                    meta_q[g] <= (g < 3);
                    sync_q[g] <= (g < 3);
                end else begin
                    meta_q[g] <= pinRaw[g];
                    sync_q[g] <= meta_q[g];
                end
            end
        end
    endgenerate

    wire sclS     = sync_q[0];
    wire sdaS     = sync_q[1];
    wire pdnS     = sync_q[2];
    wire sclRise  = sclS && !sclPrev_q;
    wire sclFall  = !sclS && sclPrev_q;
    wire startCnd = sclS && sclPrev_q && sdaPrev_q && !sdaS;
    wire stopCnd  = sclS && sclPrev_q && !sdaPrev_q && sdaS;

    // ************************************************************
    // Register state.
    // ************************************************************
    logic [4:0]             readbackLen_q;
    logic                   unlock_q;
    logic [7:0]             featurePtr_q;
    logic [FEATURE_BITS-1:0] featureBits_q;
    logic                   wrStb_q;
    logic [7:0]             wrAddr_q;
    logic [7:0]             wrData_q;

    wire hitLen  = wrStb_q && wrAddr_q == REG_READBACK_LENGTH;
    wire hitUnl  = wrStb_q && wrAddr_q == REG_FEATURE_UNLOCK;
    wire hitPtr  = wrStb_q && wrAddr_q == REG_FEATURE_BIT_POINTER
                   && unlock_q;
    wire hitBit  = wrStb_q && wrAddr_q == REG_FEATURE_BIT_COMMAND
                   && unlock_q && wrData_q[CMD_WRITE_ENABLE_BIT];
    wire curFeat = featureBits_q[featurePtr_q];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            readbackLen_q <= READBACK_LEN_RESET;
            unlock_q      <= 1'b0;
            featurePtr_q  <= FEATURE_PTR_RESET;
        end else begin
            if (hitLen) readbackLen_q <= wrData_q[4:0];
            if (hitUnl) unlock_q <= (wrData_q == UNLOCK_CODE);
            if (hitPtr) featurePtr_q <= wrData_q;
        end
    end

    generate
        for (g = 0; g < FEATURE_BITS; g++) begin : gen_feat
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    featureBits_q[g] <= FEATURE_DEFAULT[g];
                end else if (hitBit && featurePtr_q == 8'(g)) begin
                    featureBits_q[g] <= wrData_q[CMD_WRITE_STATE_BIT];
                end
            end
        end
    endgenerate

    // ************************************************************
    // Read multiplexer.
    // ************************************************************
    logic [7:0] regPtr_q;
    wire  [7:0] cmdRead = {1'b0, curFeat, 6'h00};
    wire  [7:0] rdByte  =
        (regPtr_q == REG_READBACK_LENGTH) ? {3'h0, readbackLen_q} :
        (regPtr_q == REG_FEATURE_BIT_POINTER && unlock_q) ? featurePtr_q :
        (regPtr_q == REG_FEATURE_BIT_COMMAND && unlock_q) ? cmdRead :
        8'h00;

    // ************************************************************
    // SMBus slave.
    // ************************************************************
    sifa_slv_state_t slv_q;
    logic [3:0]      bitCnt_q;
    logic [7:0]      shift_q;
    logic [7:0]      tx_q;
    logic [4:0]      remain_q;
    logic            rnw_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end else begin
            sclPrev_q <= sclS;
            sdaPrev_q <= sdaS;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            slv_q    <= SLV_IDLE;
            bitCnt_q <= 4'h0;
            shift_q  <= 8'h00;
            tx_q     <= 8'h00;
            remain_q <= 5'h00;
            rnw_q    <= 1'b0;
            regPtr_q <= 8'h00;
            sdaOeN   <= 1'b1;
            sdaOut   <= 1'b0;
            wrStb_q  <= 1'b0;
            wrAddr_q <= 8'h00;
            wrData_q <= 8'h00;
        end else begin
            wrStb_q <= 1'b0;
            if (!pdnS) begin
                slv_q  <= SLV_IDLE;
                sdaOeN <= 1'b1;
            end else if (startCnd) begin
                slv_q    <= SLV_ADDR;
                bitCnt_q <= 4'h0;
                sdaOeN   <= 1'b1;
            end else if (stopCnd) begin
                slv_q  <= SLV_IDLE;
                sdaOeN <= 1'b1;
            end else begin
                if (sclRise && bitCnt_q != 4'h8 &&
                    (slv_q == SLV_ADDR || slv_q == SLV_CMD ||
                     slv_q == SLV_WDATA)) begin
                    shift_q  <= {shift_q[6:0], sdaS};
                    bitCnt_q <= bitCnt_q + 4'h1;
                end
                case (slv_q)
                    SLV_IDLE: sdaOeN <= 1'b1;
                    SLV_ADDR: if (sclFall && bitCnt_q == 4'h8) begin
                        if (shift_q[7:1] == SMBUS_DEVICE_ADDR) begin
                            rnw_q  <= shift_q[0];
                            sdaOeN <= 1'b0;
                            slv_q  <= SLV_ADDR_ACK;
                        end else begin
                            slv_q <= SLV_IDLE;
                        end
                    end
                    SLV_ADDR_ACK: if (sclFall) begin
                        bitCnt_q <= 4'h0;
                        if (!rnw_q) begin
                            sdaOeN <= 1'b1;
                            slv_q  <= SLV_CMD;
                        end else if (readbackLen_q == 5'h00) begin
                            sdaOeN <= 1'b1;
                            slv_q  <= SLV_IDLE;
                        end else begin
                            tx_q     <= rdByte;
                            sdaOeN   <= rdByte[7];
                            bitCnt_q <= 4'h1;
                            remain_q <= readbackLen_q - 5'h01;
                            slv_q    <= SLV_RDATA;
                        end
                    end
                    SLV_CMD: if (sclFall && bitCnt_q == 4'h8) begin
                        regPtr_q <= shift_q;
                        sdaOeN   <= 1'b0;
                        slv_q    <= SLV_CMD_ACK;
                    end
                    SLV_CMD_ACK, SLV_WDATA_ACK: if (sclFall) begin
                        sdaOeN   <= 1'b1;
                        bitCnt_q <= 4'h0;
                        slv_q    <= SLV_WDATA;
                    end
                    SLV_WDATA: if (sclFall && bitCnt_q == 4'h8) begin
                        wrStb_q  <= 1'b1;
                        wrAddr_q <= regPtr_q;
                        wrData_q <= shift_q;
                        regPtr_q <= regPtr_q + 8'h01;
                        sdaOeN   <= 1'b0;
                        slv_q    <= SLV_WDATA_ACK;
                    end
                    SLV_RDATA: if (sclFall) begin
                        if (bitCnt_q == 4'h8) begin
                            sdaOeN <= 1'b1;
                            slv_q  <= SLV_RDATA_ACK;
                        end else begin
                            sdaOeN   <= tx_q[3'(4'h7 - bitCnt_q)];
                            bitCnt_q <= bitCnt_q + 4'h1;
                        end
                    end
                    SLV_RDATA_ACK: if (sclRise) begin
                        slv_q <= sdaS ? SLV_IDLE : SLV_RDATA_NXT;
                    end
                    SLV_RDATA_NXT: if (sclFall) begin
                        if (remain_q == 5'h00) begin
                            slv_q <= SLV_IDLE;
                        end else begin
                            tx_q     <= rdByte;
                            sdaOeN   <= rdByte[7];
                            bitCnt_q <= 4'h1;
                            remain_q <= remain_q - 5'h01;
                            slv_q    <= SLV_RDATA;
                        end
                    end
                    default: slv_q <= SLV_IDLE;
                endcase
                if (slv_q == SLV_ADDR_ACK && sclFall && rnw_q) begin
                    regPtr_q <= regPtr_q + 8'h01;
                end else if (slv_q == SLV_RDATA_NXT && sclFall &&
                             remain_q != 5'h00) begin
                    regPtr_q <= regPtr_q + 8'h01;
                end
            end
        end
    end

    // ************************************************************
    // Power-up sequencer.
    // ************************************************************
    sifa_powerup_seq #(
        .PWRUP_MAX_CYCLES (PWRUP_MAX_CYCLES)
    ) u_seq (
        .clk                      (clk),
        .rst                      (rst),
        .supplyOk                 (sync_q[3]),
        .refClkValid              (sync_q[4]),
        .powerDownN               (pdnS),
        .pllLocked                (sync_q[5]),
        .differentialClockOutputs (differentialClockOutputs)
    );

    // ************************************************************
    // Assertions.
    // ************************************************************
    property p_len_write;
        @(posedge clk) disable iff (rst)
        hitLen |=> readbackLen_q == $past(wrData_q[4:0]);
    endproperty
    a_len_write: assert property (p_len_write)
        else $error("Byte count not written.");

    property p_unlock;
        @(posedge clk) disable iff (rst)
        (hitUnl && wrData_q == UNLOCK_CODE) |=> unlock_q;
    endproperty
    a_unlock: assert property (p_unlock)
        else $error("Unlock code did not unlock.");

    property p_relock;
        @(posedge clk) disable iff (rst)
        (hitUnl && wrData_q != UNLOCK_CODE) |=> !unlock_q;
    endproperty
    a_relock: assert property (p_relock)
        else $error("Other value did not relock.");

    property p_locked_ignore;
        @(posedge clk) disable iff (rst)
        (!unlock_q && wrStb_q) |=> $stable(featurePtr_q)
                                   && $stable(featureBits_q);
    endproperty
    a_locked_ignore: assert property (p_locked_ignore)
        else $error("Locked write changed feature state.");

    property p_locked_read;
        @(posedge clk) disable iff (rst)
        (!unlock_q && regPtr_q == REG_FEATURE_BIT_COMMAND) |-> rdByte == 8'h00;
    endproperty
    a_locked_read: assert property (p_locked_read)
        else $error("Locked read returned data.");

    property p_read_bit;
        @(posedge clk) disable iff (rst)
        (unlock_q && regPtr_q == REG_FEATURE_BIT_COMMAND)
            |-> rdByte == {1'b0, featureBits_q[featurePtr_q], 6'h00};
    endproperty
    a_read_bit: assert property (p_read_bit)
        else $error("Feature bit not in bit 6.");

    property p_bit_write;
        @(posedge clk) disable iff (rst)
        hitBit |=> featureBits_q[$past(featurePtr_q)]
                   == $past(wrData_q[CMD_WRITE_STATE_BIT]);
    endproperty
    a_bit_write: assert property (p_bit_write)
        else $error("Feature bit not updated.");

    property p_bit_hold;
        @(posedge clk) disable iff (rst)
        !hitBit |=> $stable(featureBits_q);
    endproperty
    a_bit_hold: assert property (p_bit_hold)
        else $error("Feature bit changed without enable.");

    property p_pdn_quiet;
        @(posedge clk) disable iff (rst)
        !pdnS |=> slv_q == SLV_IDLE && sdaOeN && !wrStb_q;
    endproperty
    a_pdn_quiet: assert property (p_pdn_quiet)
        else $error("Bus active in power-down.");

    c_unlock: cover property (@(posedge clk) disable iff (rst)
        hitUnl && wrData_q == UNLOCK_CODE);
    c_bit_write: cover property (@(posedge clk) disable iff (rst) hitBit);
    c_read: cover property (@(posedge clk) disable iff (rst)
        slv_q == SLV_RDATA_NXT ##[1:300] slv_q == SLV_RDATA);

endmodule

// [sifa_host_model.sv]
// SMBus host model that drives the control bus of the clock buffer.
`timescale 1ns/10ps
module sifa_host_model (
    input  wire logic clk,
    output logic      scl,
    output logic      sdaHost,
    input  wire logic sdaWire
);
    import sifa_pkg::*;
    initial begin
        scl = 1'b1;
        sdaHost = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic sbit(input logic b, output logic r);
        sdaHost <= b;
        w(6);
        scl <= 1'b1;
        w(10);
        r = sdaWire;
        scl <= 1'b0;
        w(4);
    endtask
    task automatic byt(input logic [7:0] d, input logic nak,
                       output logic [7:0] q, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) sbit(d[i], q[i]);
        sbit(nak, a);
        ack = ~a;
    endtask
    task automatic start();
        sdaHost <= 1'b1;
        w(4);
        scl <= 1'b1;
        w(10);
        sdaHost <= 1'b0;
        w(10);
        scl <= 1'b0;
        w(4);
    endtask
    task automatic stop();
        sdaHost <= 1'b0;
        w(6);
        scl <= 1'b1;
        w(10);
        sdaHost <= 1'b1;
        w(10);
    endtask
    task automatic wr(input logic [7:0] off, d, output logic ok);
        logic [7:0] q;
        logic a0, a1, a2;
        start();
        byt({SMBUS_DEVICE_ADDR, 1'b0}, 1'b1, q, a0);
        byt(off, 1'b1, q, a1);
        byt(d, 1'b1, q, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask
    task automatic rd(input logic [7:0] off, input int n,
                      output logic [15:0] q);
        logic [7:0] b;
        logic       a;
        q = '0;
        start();
        byt({SMBUS_DEVICE_ADDR, 1'b0}, 1'b1, b, a);
        byt(off, 1'b1, b, a);
        start();
        byt({SMBUS_DEVICE_ADDR, 1'b1}, 1'b1, b, a);
        for (int i = 1; i <= n; i++) begin
            byt(8'hff, i == n, b, a);
            q = {q[7:0], b};
        end
        stop();
    endtask
    task automatic setbit(input logic [7:0] addr, input logic s);
        logic ok;
        wr(8'h08, UNLOCK_CODE, ok);
        wr(8'h09, addr, ok);
        wr(8'h0a, {6'h20, s, 1'b0}, ok);
        wr(8'h0a, 8'h00, ok);
    endtask
endmodule

// [sifa_smbus_feature_access_tb.sv]
// Self-checking testbench of the clock buffer control logic.
`timescale 1ns/10ps
module sifa_smbus_feature_access_tb;
    import sifa_pkg::*;
    typedef struct {logic [7:0] wo, wd, ro, re;} sifa_row_t;
    logic        clk, rst, sdaOut, sdaOeN, powerDownN, supplyOk, ok;
    logic        refClkValid, pllLocked, scl, sdaHost;
    logic [18:0] outs;
    logic [15:0] q;
    int          miscompares = 0;
    int          check_count = 0;
    int          n;
    wire         sdaWire = sdaHost & (sdaOeN | sdaOut);
    sifa_row_t rows [11] = '{'{8'h07, 8'h03, 8'h07, 8'h03},
        '{8'h08, 8'hbb, 8'h08, 8'h00}, '{8'h09, 8'h84, 8'h09, 8'h84},
        '{8'h0a, 8'h82, 8'h0a, 8'h40}, '{8'h0a, 8'h00, 8'h0a, 8'h40},
        '{8'h09, 8'h85, 8'h0a, 8'h00}, '{8'h0a, 8'h02, 8'h0a, 8'h00},
        '{8'h08, 8'h5a, 8'h09, 8'h00}, '{8'h09, 8'h84, 8'h0a, 8'h00},
        '{8'h08, 8'hbb, 8'h09, 8'h85}, '{8'h0b, 8'hff, 8'h0b, 8'h00}};
    sifa_smbus_feature_access #(.FEATURE_DEFAULT(256'h1 << 143),
        .PWRUP_MAX_CYCLES(4000)) sifa_smbus_feature_access_inst (
        .clk(clk), .rst(rst), .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaOut),
        .sdaOeN(sdaOeN), .power_down_n(powerDownN), .supplyOk(supplyOk),
        .refClkValid(refClkValid), .pllLocked(pllLocked),
        .differentialClockOutputs(outs));
    sifa_host_model sifa_host_model_inst (.clk(clk), .scl(scl),
        .sdaHost(sdaHost), .sdaWire(sdaWire));
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic waitOuts(input logic [18:0] v);
        n = 0;
        while (outs !== v && n < 5000) begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        chk(24'(n < 5000), 24'h1);
    endtask
    task automatic rdChk(input logic [7:0] off, input logic [7:0] e);
        sifa_host_model_inst.rd(off, 1, q);
        chk(24'(q), 24'(e));
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #5_000_000;
        miscompares++;
        results();
    end
    initial begin
        {rst, powerDownN} = 2'b11;
        {supplyOk, refClkValid, pllLocked} = 3'b000;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        supplyOk <= 1'b1;
        repeat (3200) @(posedge clk);
        chk(24'(outs), 24'h0);
        {refClkValid, pllLocked} <= 2'b11;
        waitOuts('1);
        chk(24'(n), 24'h3);
        supplyOk <= 1'b0;
        waitOuts('0);
        supplyOk <= 1'b1;
        @(posedge clk);
        waitOuts('1);
        chk(24'(n >= 2990 && n < 3100), 24'h1);
        powerDownN <= 1'b0;
        repeat (10) @(posedge clk);
        chk(24'(outs), 24'h0);
        sifa_host_model_inst.wr(8'h07, 8'h1f, ok);
        chk(24'(ok), 24'h0);
        powerDownN <= 1'b1;
        repeat (10) @(posedge clk);
        rdChk(8'h07, 8'h08);
        foreach (rows[i]) begin
            sifa_host_model_inst.wr(rows[i].wo, rows[i].wd, ok);
            chk(24'(ok), 24'h1);
            rdChk(rows[i].ro, rows[i].re);
        end
        sifa_host_model_inst.wr(8'h07, 8'h02, ok);
        sifa_host_model_inst.rd(8'h09, 2, q);
        chk(24'(q), 24'h8500);
        sifa_host_model_inst.wr(8'h07, 8'h01, ok);
        sifa_host_model_inst.rd(8'h09, 2, q);
        chk(24'(q), 24'h85ff);
        sifa_host_model_inst.wr(8'h09, 8'h8f, ok);
        rdChk(8'h0a, 8'h40);
        sifa_host_model_inst.setbit(8'h8f, 1'b0);
        rdChk(8'h0a, 8'h00);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        rdChk(8'h07, 8'h08);
        sifa_host_model_inst.wr(8'h08, 8'hbb, ok);
        sifa_host_model_inst.wr(8'h09, 8'h8f, ok);
        rdChk(8'h0a, 8'h40);
        results();
    end
endmodule
